//--- verilog/nfx_pkg.sv
// package of constants for the negate-file execution block
package nfx_pkg;
  localparam logic [6:0]  OPC_NEGATE_PAT = 7'h36;  // bits 15:9 = 0110 110
  localparam int          OPC_HI_POS     = 9;
  localparam int          BANK_BIT_POS   = 8;
  localparam logic [7:0]  LIT_OFS_LIMIT  = 8'h5f;
  localparam logic [7:0]  ACC_SPLIT      = 8'h60;  // access bank low/high split
  localparam logic [3:0]  ACC_HIGH_BANK  = 4'hf;
  localparam logic [3:0]  BANK_SEL_RESET = 4'h0;
  localparam logic [11:0] FSR2_RESET     = 12'h000;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [4:0]  FLAGS_RESET    = 5'h00;
  localparam int          FLG_C          = 0;
  localparam int          FLG_DC         = 1;
  localparam int          FLG_Z          = 2;
  localparam int          FLG_OV         = 3;
  localparam int          FLG_N          = 4;
  typedef enum logic [1:0] {NFX_Q1, NFX_Q2, NFX_Q3, NFX_Q4} nfx_phase_t;
endpackage

//--- verilog/nfx_alu.sv
// negate arithmetic and flag generation
`timescale 1ns/1ps
module nfx_alu (
  // operand
  input  wire logic [7:0] i_operand,
  // result
  output logic [7:0]      o_result,
  output logic [4:0]      o_flags
);
  wire logic [7:0] inv      = ~i_operand;
  wire logic [8:0] sum      = {1'b0, inv} + 9'h001;
  wire logic [4:0] sum_low  = {1'b0, inv[3:0]} + 5'h01;
  wire logic [7:0] res      = sum[7:0];
  assign o_result = res;
  // overflow only for 0x80, where the signed negation has no answer
  assign o_flags[nfx_pkg::FLG_C]  = sum[8];
  assign o_flags[nfx_pkg::FLG_DC] = sum_low[4];
  assign o_flags[nfx_pkg::FLG_Z]  = (res == 8'h00);
  assign o_flags[nfx_pkg::FLG_OV] = ~inv[7] & res[7];
  assign o_flags[nfx_pkg::FLG_N]  = res[7];
endmodule // nfx_alu

//--- verilog/nfx_exec.sv
// negate-file instruction decode and four-phase execution
`timescale 1ns/1ps
module nfx_exec (
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RESET,
  // instruction fetch
  input  wire logic [15:0] I_INSTR,
  input  wire logic        I_INSTR_VALID,
  // core state
  input  wire logic [3:0]  I_BANK_SELECT_REG,
  input  wire logic [11:0] I_FSR2,
  input  wire logic        I_EXT_SET_EN,
  // data memory read data
  input  wire logic [7:0]  I_MEM_RDATA,
  // data memory access
  output logic [11:0]      O_MEM_ADDR,
  output logic             O_MEM_RD,
  output logic             O_MEM_WR,
  output logic [7:0]       O_MEM_WDATA,
  // status
  output logic [4:0]       O_FLAGS,
  output logic             O_FLAGS_WE,
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic [1:0]       O_PHASE
);
  ////////////////////////////////////////////////////////////////////////
  nfx_pkg::nfx_phase_t phase;
  nfx_pkg::nfx_phase_t next_phase;
  logic [15:0] instr;
  logic [11:0] addr;
  logic [7:0]  operand;
  logic [7:0]  result;
  logic [4:0]  flags_q;
  logic [11:0] next_addr;
  wire  logic [7:0] alu_res;
  wire  logic [4:0] alu_flags;

  // decode; other opcodes are left to the rest of the core
  wire logic       is_negate_file_instr  = I_INSTR_VALID &&
      (I_INSTR[15:nfx_pkg::OPC_HI_POS] == nfx_pkg::OPC_NEGATE_PAT);
  wire logic       bank_bit = instr[nfx_pkg::BANK_BIT_POS];
  wire logic [7:0] f_op     = instr[7:0];
  wire logic       use_lit  = !bank_bit && I_EXT_SET_EN &&
      (f_op <= nfx_pkg::LIT_OFS_LIMIT);
  wire logic [11:0] lit_addr = I_FSR2 + {4'h0, f_op};
  wire logic [11:0] acc_addr = (f_op < nfx_pkg::ACC_SPLIT) ?
      {4'h0, f_op} : {nfx_pkg::ACC_HIGH_BANK, f_op};
  wire logic [11:0] bsr_addr = {I_BANK_SELECT_REG, f_op};

  always_comb begin
    if (bank_bit) begin
      next_addr = bsr_addr;
    end else if (use_lit) begin
      next_addr = lit_addr;
    end else begin
      next_addr = acc_addr;
    end
  end

  always_comb begin
    unique case (phase)
      nfx_pkg::NFX_Q1: next_phase = is_negate_file_instr ? nfx_pkg::NFX_Q2 : nfx_pkg::NFX_Q1;
      nfx_pkg::NFX_Q2: next_phase = nfx_pkg::NFX_Q3;
      nfx_pkg::NFX_Q3: next_phase = nfx_pkg::NFX_Q4;
      nfx_pkg::NFX_Q4: next_phase = nfx_pkg::NFX_Q1;
    endcase
  end

  nfx_alu u_alu (
    .i_operand (operand),
    .o_result  (alu_res),
    .o_flags   (alu_flags)
  );

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      phase <= nfx_pkg::NFX_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // instruction word latched at decode so fetch may move on
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      instr <= 16'h0000;
    end else if (phase == nfx_pkg::NFX_Q1 && is_negate_file_instr) begin
      instr <= I_INSTR;
    end
  end

  // address is fixed in q2 and reused for the write: same location
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      addr    <= 12'h000;
      operand <= nfx_pkg::DATA_RESET;
    end else if (phase == nfx_pkg::NFX_Q2) begin
      addr    <= next_addr;
    end else if (phase == nfx_pkg::NFX_Q3) begin
      operand <= I_MEM_RDATA;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      result  <= nfx_pkg::DATA_RESET;
      flags_q <= nfx_pkg::FLAGS_RESET;
    end else if (phase == nfx_pkg::NFX_Q4) begin
      result  <= alu_res;
      flags_q <= alu_flags;
    end
  end

  // outputs, all registered
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      O_MEM_ADDR  <= 12'h000;
      O_MEM_RD    <= 1'b0;
      O_MEM_WR    <= 1'b0;
      O_MEM_WDATA <= nfx_pkg::DATA_RESET;
      O_FLAGS     <= nfx_pkg::FLAGS_RESET;
      O_FLAGS_WE  <= 1'b0;
      O_BUSY      <= 1'b0;
      O_DONE      <= 1'b0;
      O_PHASE     <= 2'h0;
    end else begin
      O_MEM_ADDR  <= (phase == nfx_pkg::NFX_Q2) ? next_addr : addr;
      O_MEM_RD    <= (phase == nfx_pkg::NFX_Q2);
      O_MEM_WR    <= (phase == nfx_pkg::NFX_Q4);
      O_MEM_WDATA <= (phase == nfx_pkg::NFX_Q4) ? alu_res : result;
      O_FLAGS     <= (phase == nfx_pkg::NFX_Q4) ? alu_flags : flags_q;
      O_FLAGS_WE  <= (phase == nfx_pkg::NFX_Q4);
      O_BUSY      <= (next_phase != nfx_pkg::NFX_Q1);
      O_DONE      <= (phase == nfx_pkg::NFX_Q4);
      O_PHASE     <= next_phase;
    end
  end
endmodule // nfx_exec

//--- verif/nfx_checker.sv
// assertions for the negate-file execution block
`timescale 1ns/1ps
module nfx_checker (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RESET,
  input wire logic [15:0] I_INSTR,
  input wire logic        I_INSTR_VALID,
  input wire logic [3:0]  I_BANK_SELECT_REG,
  input wire logic [11:0] I_FSR2,
  input wire logic        I_EXT_SET_EN,
  input wire logic [7:0]  I_MEM_RDATA,
  input wire logic [11:0] O_MEM_ADDR,
  input wire logic        O_MEM_RD,
  input wire logic        O_MEM_WR,
  input wire logic [7:0]  O_MEM_WDATA,
  input wire logic [4:0]  O_FLAGS,
  input wire logic        O_FLAGS_WE,
  input wire logic        O_BUSY,
  input wire logic        O_DONE,
  input wire logic [1:0]  O_PHASE
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  sequence take(a);
    I_INSTR_VALID && O_PHASE == 2'h0 && I_INSTR[15:8] == {nfx_pkg::OPC_NEGATE_PAT, a};
  endsequence
  a_one_cycle: assert property (O_MEM_RD |-> ##2 O_MEM_WR && O_FLAGS_WE && O_DONE)
    else $error("write phase late");
  a_same_addr: assert property (O_MEM_WR |-> O_MEM_ADDR == $past(O_MEM_ADDR, 2))
    else $error("write address differs");
  a_neg_data: assert property (O_MEM_RD |-> ##2 O_MEM_WDATA == 8'h00 - $past(I_MEM_RDATA, 2))
    else $error("result not negated");
  a_flag_nz: assert property (O_FLAGS_WE |-> O_FLAGS[2] == (O_MEM_WDATA == 8'h00)
    && O_FLAGS[4] == O_MEM_WDATA[7]) else $error("flags wrong");
  a_bank_addr: assert property (take(1'b1) |-> ##2 O_MEM_RD
    && O_MEM_ADDR == {I_BANK_SELECT_REG, $past(I_INSTR[7:0], 2)}) else $error("bank addr");
  a_busy_phase: assert property (O_BUSY == (O_PHASE != 2'h0))
    else $error("busy and phase disagree");
  a_access_addr: assert property (take(1'b0) ##0 !I_EXT_SET_EN |-> ##2 O_MEM_ADDR ==
    {($past(I_INSTR[7:0], 2) < 8'h60) ? 4'h0 : 4'hf, $past(I_INSTR[7:0], 2)})
    else $error("access addr");
  a_lit_addr: assert property (take(1'b0) ##0 (I_EXT_SET_EN && I_INSTR[7:0] <= 8'h5f)
    |-> ##2 O_MEM_ADDR == I_FSR2 + {4'h0, $past(I_INSTR[7:0], 2)}) else $error("offset addr");
endmodule // nfx_checker
bind nfx_exec nfx_checker nfx_checker_i (.*);

//--- verif/tb.sv
// self-checking bench for the negate-file execution block
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, ext = 1'b0, mrd, mwr, fwe, bsy, dn;
  logic [15:0] ins = 16'h0000;
  logic [3:0]  bank_select_reg = 4'h0;
  logic [11:0] fsr = 12'hffe, adr;
  logic [7:0]  rd = 8'h00, wd;
  logic [4:0]  flg;
  logic [1:0]  ph;
  int          bad_count = 0, checked = 0;
  nfx_exec nfx_exec_i (.I_CLK_SYS(clk), .I_RESET(rst), .I_INSTR(ins), .I_INSTR_VALID(vld),
    .I_BANK_SELECT_REG(bank_select_reg), .I_FSR2(fsr), .I_EXT_SET_EN(ext), .I_MEM_RDATA(rd),
    .O_MEM_ADDR(adr), .O_MEM_RD(mrd), .O_MEM_WR(mwr), .O_MEM_WDATA(wd), .O_FLAGS(flg),
    .O_FLAGS_WE(fwe), .O_BUSY(bsy), .O_DONE(dn), .O_PHASE(ph));
  initial forever #5 clk = ~clk;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wt(input logic ok);
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish();
    end
  endtask
  // one whole instruction: word in, operand served, result and flags judged
  task automatic op(input logic a, input logic [7:0] f, d, input logic [11:0] ea);
    logic [7:0] r;
    int n;
    r = 8'h00 - d;
    @(negedge clk);
    ins = {nfx_pkg::OPC_NEGATE_PAT, a, f};
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    for (n = 0; n < 8 && mrd !== 1'b1; n++) @(negedge clk);
    wt(mrd);
    chk(adr, ea);
    chk({9'h0, bsy, ph}, {9'h0, 1'b1, 2'h2});
    rd = d;
    for (n = 0; n < 8 && dn !== 1'b1; n++) @(negedge clk);
    wt(dn);
    chk(adr, ea);
    chk({9'h0, bsy, ph}, 12'h000);
    chk({4'h0, wd}, {4'h0, r});
    chk({5'h0, mwr, fwe, flg}, {7'h03, r[7], d == 8'h80, r == 8'h00, d[3:0] == 4'h0, d == 8'h00});
    $display("test done at %h", ea);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    bank_select_reg = 4'h3;
    op(1'b1, 8'h3a, 8'h3a, 12'h33a);
    op(1'b0, 8'h10, 8'h00, 12'h010);
    op(1'b0, 8'h80, 8'h80, 12'hf80);
    ext = 1'b1;
    op(1'b0, 8'h05, 8'h01, 12'h003);
    op(1'b0, 8'h60, 8'h10, 12'hf60);
    op(1'b1, 8'h5f, 8'hf0, 12'h35f);
    tally_and_finish();
  end
endmodule // tb
